// File: bst_pkg.sv
// Package: boundary-scan test port constants and types
package bst_pkg;
  // Instruction codes (instr_bit_two..instr_bit_zero)
  localparam logic [2:0] BST_EXTEST   = 3'h0;
  localparam logic [2:0] BST_SAMPLE   = 3'h1;
  localparam logic [2:0] BST_USER1    = 3'h2;
  localparam logic [2:0] BST_USER2    = 3'h3;
  localparam logic [2:0] BST_READBACK = 3'h4;
  localparam logic [2:0] BST_CONFIG   = 3'h5;
  localparam logic [2:0] BST_RESVD    = 3'h6;
  localparam logic [2:0] BST_BYPASS   = 3'h7;
  // Instruction register reset value and capture pattern
  localparam logic [2:0] BST_IR_RESET   = 3'h7;
  localparam logic [2:0] BST_IR_CAPTURE = 3'h1;
  // Data register layout: two test-out cells lead, update cell last
  localparam int BST_POS_TOUT_EN  = 0;
  localparam int BST_POS_TOUT_VAL = 1;
  localparam int BST_POS_PAD0     = 2;
  localparam int BST_CELLS_PER_PAD = 3;
  localparam int BST_MODE_CELLS   = 5;  // mode zero in, mode two in, mode one x3
  // Default counts
  localparam int BST_NUM_PADS     = 4;
  localparam int BST_FIFO_DEPTH   = 16;
  // Controller states
  typedef enum logic [3:0] {
    BST_TLR  = 4'h0, BST_RTI  = 4'h1, BST_SDRS = 4'h2, BST_CDR  = 4'h3,
    BST_SDR  = 4'h4, BST_E1DR = 4'h5, BST_PDR  = 4'h6, BST_E2DR = 4'h7,
    BST_UDR  = 4'h8, BST_SIRS = 4'h9, BST_CIR  = 4'hA, BST_SIR  = 4'hB,
    BST_E1IR = 4'hC, BST_PIR  = 4'hD, BST_E2IR = 4'hE, BST_UIR  = 4'hF
  } bst_state_t;
endpackage : bst_pkg

// File: bst_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module bst_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be power of 2");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // Pointer compare gives honest full and empty
  assign full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty = (wr_q == rd_q);
  assign push  = in_valid_i && in_ready_o;
  assign pop   = !empty && (!out_valid_o || out_ready_i);

  // Storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  // Pointers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end

  // Registered read data and flags
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
      in_ready_o  <= 1'b0;
    end else begin
      in_ready_o <= !((wr_q + (push ? 1'b1 : 1'b0)) - (rd_q + (pop ? 1'b1 : 1'b0))
                      >= (AW+1)'(DEPTH));
      if (pop) begin
        out_valid_o <= 1'b1;
        out_data_o  <= mem_q[rd_q[AW-1:0]];
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
    end
  end

  a_fifo_no_overflow: assert property (@(posedge clk_i) disable iff (rst_i)
    push |-> !full) else $error("FIFO pushed while full");
endmodule : bst_fifo

// File: bst_port.sv
// Boundary-scan test access port with data register and user hooks
`timescale 1ns/1ps
module bst_port
  import bst_pkg::*;
#(
  parameter int NUM_PADS   = bst_pkg::BST_NUM_PADS,
  parameter int FIFO_DEPTH = bst_pkg::BST_FIFO_DEPTH
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Link side, inputs on test clock, outputs registered on system clock
  input  wire logic                tck_i,
  input  wire logic                tms_i,
  input  wire logic                tdi_i,
  output logic                     tdo_o,
  output logic                     tdo_oe_n_o,
  // Device-side configuration and mode
  input  wire logic                configuring_i,
  input  wire logic                keepalive_i,
  input  wire logic                user_tdo_val_i,
  input  wire logic                user_tdo_oe_n_i,
  // Pads in perimeter order, pad 0 nearest the upper right corner
  input  wire logic [NUM_PADS-1:0] pad_in_i,
  input  wire logic [NUM_PADS-1:0] core_out_i,
  input  wire logic [NUM_PADS-1:0] core_oe_n_i,
  output logic      [NUM_PADS-1:0] pad_out_o,
  output logic      [NUM_PADS-1:0] pad_oe_n_o,
  // Mode pins
  input  wire logic                mode_pin_zero_i,
  input  wire logic                mode_pin_two_i,
  input  wire logic                core_mode_one_i,
  input  wire logic                core_mode_one_oe_n_i,
  output logic                     mode_pin_one_o,
  output logic                     mode_pin_one_oe_n_o,
  // Internal capture cells and user hooks
  input  wire logic                core_tout_en_i,
  input  wire logic                core_tout_val_i,
  input  wire logic                user_test_out_one_i,
  input  wire logic                user_test_out_two_i,
  input  wire logic                readback_bit_i,
  input  wire logic                config_dout_i,
  output logic                     internal_update_cell_o,
  output logic                     user_tck_o,
  output logic                     user_tms_o,
  output logic                     user_tdi_o,
  // Configuration bits shifted in by the configure instruction
  output logic                     cfg_valid_o,
  input  wire logic                cfg_ready_i,
  output logic                     cfg_data_o,
  output logic                     scan_active_o
);
  localparam int DR_LEN = BST_POS_PAD0 + NUM_PADS*BST_CELLS_PER_PAD
                          + BST_MODE_CELLS + 1;
  localparam int POS_MODE = BST_POS_PAD0 + NUM_PADS*BST_CELLS_PER_PAD;
  localparam int POS_UPD  = DR_LEN - 1;
  initial begin
    if (NUM_PADS < 1) $error("NUM_PADS must be at least 1");
  end

  // Instruction decode helper used in two places
  function automatic logic drives_pads(input logic [2:0] ir);
    drives_pads = (ir == BST_EXTEST);
  endfunction : drives_pads

  bst_state_t           st_q;
  bst_state_t           st_d;
  logic [2:0]           ir_sh_q;
  logic [2:0]           ir_q;
  logic [DR_LEN-1:0]    dr_sh_q;
  logic [DR_LEN-1:0]    dr_up_q;
  logic                 byp_q;
  logic                 tdo_n_q;
  logic                 tdo_en_n_q;
  logic                 cfg_tgl_q;
  logic                 cfg_bit_q;
  logic [DR_LEN-1:0]    cap;
  logic                 ser;
  // System-domain synchronisers and state
  logic [1:0]           cfg_s_q;
  logic [1:0]           keep_s_q;
  logic [2:0]           tgl_s_q;
  logic                 bit_s_q;
  logic                 push;
  logic                 push_rdy;
  logic                 ext_t_q;
  logic [1:0]           ext_s_q;
  logic                 upd_tgl_q;
  logic [2:0]           upd_s_q;
  logic [DR_LEN-1:0]    dr_up_s_q;
  logic [1:0]           tdo_s_q;
  logic [1:0]           tdo_en_s_q;
  logic [1:0]           cfg_t_q;
  logic [1:0]           keep_t_q;
  logic                 live_q;
  logic [1:0]           tms_s_q;
  logic [1:0]           tck_s_q;
  logic [1:0]           tdi_s_q;

  // Scan is live during configuration, or afterwards with keepalive
  logic live_tck;
  assign live_tck = cfg_t_q[1] | keep_t_q[1];

  // Controller next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      BST_TLR:  st_d = tms_i ? BST_TLR  : BST_RTI;
      BST_RTI:  st_d = tms_i ? BST_SDRS : BST_RTI;
      BST_SDRS: st_d = tms_i ? BST_SIRS : BST_CDR;
      BST_CDR:  st_d = tms_i ? BST_E1DR : BST_SDR;
      BST_SDR:  st_d = tms_i ? BST_E1DR : BST_SDR;
      BST_E1DR: st_d = tms_i ? BST_UDR  : BST_PDR;
      BST_PDR:  st_d = tms_i ? BST_E2DR : BST_PDR;
      BST_E2DR: st_d = tms_i ? BST_UDR  : BST_SDR;
      BST_UDR:  st_d = tms_i ? BST_SDRS : BST_RTI;
      BST_SIRS: st_d = tms_i ? BST_TLR  : BST_CIR;
      BST_CIR:  st_d = tms_i ? BST_E1IR : BST_SIR;
      BST_SIR:  st_d = tms_i ? BST_E1IR : BST_SIR;
      BST_E1IR: st_d = tms_i ? BST_UIR  : BST_PIR;
      BST_PIR:  st_d = tms_i ? BST_E2IR : BST_PIR;
      BST_E2IR: st_d = tms_i ? BST_UIR  : BST_SIR;
      BST_UIR:  st_d = tms_i ? BST_SDRS : BST_RTI;
      default:  st_d = BST_TLR;
    endcase
  end

  // Controller state; held in reset when scan is not live
  always_ff @(posedge tck_i or posedge rst_i) begin
    if (rst_i) begin
      st_q     <= BST_TLR;
      cfg_t_q  <= '0;
      keep_t_q <= '0;
    end else begin
      cfg_t_q  <= {cfg_t_q[0], configuring_i};
      keep_t_q <= {keep_t_q[0], keepalive_i};
      st_q     <= live_tck ? st_d : BST_TLR;
    end
  end

  // Capture vector: test-out cells, pad triplets, mode cells, update
  always_comb begin
    cap = '0;
    cap[BST_POS_TOUT_EN]  = core_tout_en_i;
    cap[BST_POS_TOUT_VAL] = core_tout_val_i;
    for (int p = 0; p < NUM_PADS; p++) begin
      // In, Out, 3-State per pad, perimeter order
      cap[BST_POS_PAD0 + p*BST_CELLS_PER_PAD]     = pad_in_i[p];
      cap[BST_POS_PAD0 + p*BST_CELLS_PER_PAD + 1] = core_out_i[p];
      cap[BST_POS_PAD0 + p*BST_CELLS_PER_PAD + 2] = core_oe_n_i[p];
    end
    cap[POS_MODE]     = mode_pin_zero_i;
    cap[POS_MODE + 1] = mode_pin_two_i;
    cap[POS_MODE + 2] = 1'b0;  // Mode one has no input path
    cap[POS_MODE + 3] = core_mode_one_i;
    cap[POS_MODE + 4] = core_mode_one_oe_n_i;
    cap[POS_UPD]      = dr_up_q[POS_UPD];
  end

  // Instruction shift and update
  always_ff @(posedge tck_i or posedge rst_i) begin
    if (rst_i) begin
      ir_sh_q <= BST_IR_RESET;
      ir_q    <= BST_IR_RESET;
      ext_t_q <= 1'b0;
    end else if (st_q == BST_TLR) begin
      ir_q    <= BST_IR_RESET;
      ext_t_q <= drives_pads(BST_IR_RESET);
    end else if (st_q == BST_CIR) begin
      ir_sh_q <= BST_IR_CAPTURE;
    end else if (st_q == BST_SIR) begin
      ir_sh_q <= {tdi_i, ir_sh_q[2:1]};
    end else if (st_q == BST_UIR) begin
      ir_q    <= (ir_sh_q == BST_RESVD) ? BST_BYPASS : ir_sh_q;
      ext_t_q <= drives_pads(ir_sh_q);
    end
  end

  // Data register, bypass and configure bit stream
  always_ff @(posedge tck_i or posedge rst_i) begin
    if (rst_i) begin
      dr_sh_q   <= '0;
      dr_up_q   <= '0;
      byp_q     <= 1'b0;
      cfg_tgl_q <= 1'b0;
      cfg_bit_q <= 1'b0;
      upd_tgl_q <= 1'b0;
    end else begin
      if (st_q == BST_CDR) begin
        dr_sh_q <= cap;
        byp_q   <= 1'b0;
      end else if (st_q == BST_SDR) begin
        dr_sh_q <= {tdi_i, dr_sh_q[DR_LEN-1:1]};
        byp_q   <= tdi_i;
        if (ir_q == BST_CONFIG) begin
          cfg_bit_q <= tdi_i;
          cfg_tgl_q <= ~cfg_tgl_q;
        end
      end
      if (st_q == BST_UDR && (ir_q == BST_EXTEST || ir_q == BST_SAMPLE)) begin
        dr_up_q   <= dr_sh_q;
        upd_tgl_q <= ~upd_tgl_q;  // Tells the system side a new word
      end
    end
  end

  // Serial output source
  always_comb begin
    case (ir_q)
      BST_EXTEST, BST_SAMPLE: ser = dr_sh_q[0];
      BST_USER1:              ser = user_test_out_one_i;
      BST_USER2:              ser = user_test_out_two_i;
      BST_READBACK:           ser = readback_bit_i;
      BST_CONFIG:             ser = config_dout_i;
      default:                ser = byp_q;
    endcase
    if (st_q == BST_SIR) ser = ir_sh_q[0];  // Instruction shift out
  end

  // Output changes on the falling test clock edge
  always_ff @(negedge tck_i or posedge rst_i) begin
    if (rst_i) begin
      tdo_n_q    <= 1'b0;
      tdo_en_n_q <= 1'b1;
    end else begin
      tdo_n_q    <= ser;
      tdo_en_n_q <= !(st_q == BST_SDR || st_q == BST_SIR);
    end
  end

  // System-side synchronisers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_s_q  <= '0;
      keep_s_q <= '0;
      tgl_s_q  <= '0;
      bit_s_q  <= 1'b0;
      ext_s_q  <= '0;
      upd_s_q  <= '0;
      dr_up_s_q <= '0;
      tdo_s_q  <= '0;
      tdo_en_s_q <= '1;
      tms_s_q  <= 2'h3;
      tck_s_q  <= '0;
      tdi_s_q  <= '0;
    end else begin
      cfg_s_q  <= {cfg_s_q[0], configuring_i};
      keep_s_q <= {keep_s_q[0], keepalive_i};
      tgl_s_q  <= {tgl_s_q[1:0], cfg_tgl_q};
      bit_s_q  <= cfg_bit_q;  // Stable for a whole test clock period
      ext_s_q  <= {ext_s_q[0], ext_t_q};
      upd_s_q  <= {upd_s_q[1:0], upd_tgl_q};
      tdo_s_q  <= {tdo_s_q[0], tdo_n_q};
      tdo_en_s_q <= {tdo_en_s_q[0], tdo_en_n_q};
      if (upd_s_q[2] ^ upd_s_q[1]) dr_up_s_q <= dr_up_q;  // Settled word
      tms_s_q  <= {tms_s_q[0], tms_i};
      tck_s_q  <= {tck_s_q[0], tck_i};
      tdi_s_q  <= {tdi_s_q[0], tdi_i};
    end
  end

  // Toggle edge marks a new configure bit
  assign push = tgl_s_q[2] ^ tgl_s_q[1];

  bst_fifo #(
    .WIDTH (1),
    .DEPTH (FIFO_DEPTH)
  ) u_cfg_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push),
    .in_ready_o  (push_rdy),
    .in_data_i   (bit_s_q),
    .out_valid_o (cfg_valid_o),
    .out_ready_i (cfg_ready_i),
    .out_data_o  (cfg_data_o)
  );

  // Registered outputs: pads, test output, user-side copies
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      live_q                 <= 1'b0;
      tdo_o                  <= 1'b0;
      tdo_oe_n_o             <= 1'b1;
      pad_out_o              <= '0;
      pad_oe_n_o             <= '1;
      mode_pin_one_o         <= 1'b0;
      mode_pin_one_oe_n_o    <= 1'b1;
      internal_update_cell_o <= 1'b0;
      user_tck_o             <= 1'b0;
      user_tms_o             <= 1'b1;
      user_tdi_o             <= 1'b0;
      scan_active_o          <= 1'b0;
    end else begin
      live_q        <= cfg_s_q[1] | keep_s_q[1];
      scan_active_o <= live_q;
      // Scan data, or a plain three-state user output
      tdo_o      <= live_q ? tdo_s_q[1] : user_tdo_val_i;
      tdo_oe_n_o <= live_q ? tdo_en_s_q[1] : user_tdo_oe_n_i;
      for (int p = 0; p < NUM_PADS; p++) begin
        // Pads driven from the register only in external
        pad_out_o[p]  <= ext_s_q[1] ?
                         dr_up_s_q[BST_POS_PAD0 + p*BST_CELLS_PER_PAD + 1]
                         : core_out_i[p];
        pad_oe_n_o[p] <= ext_s_q[1] ?
                         dr_up_s_q[BST_POS_PAD0 + p*BST_CELLS_PER_PAD + 2]
                         : core_oe_n_i[p];
      end
      // Mode one follows the core, or the update register in external test
      mode_pin_one_o      <= ext_s_q[1] ? dr_up_s_q[POS_MODE + 3]
                                        : core_mode_one_i;
      mode_pin_one_oe_n_o <= ext_s_q[1] ? dr_up_s_q[POS_MODE + 4]
                                        : core_mode_one_oe_n_i;
      internal_update_cell_o <= dr_up_s_q[POS_UPD];
      // Test inputs routed to user logic
      user_tck_o <= tck_s_q[1];
      user_tms_o <= tms_s_q[1];
      user_tdi_o <= tdi_s_q[1];
    end
  end

  a_pads_follow_core: assert property (@(posedge clk_i) disable iff (rst_i)
    !ext_s_q[1] |=> pad_out_o == $past(core_out_i))
    else $error("Pads not from core outside external test");
  a_tdo_user_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !live_q |=> tdo_o == $past(user_tdo_val_i))
    else $error("Test output not user driven when idle");
  a_tms_high_reset: assert property (@(posedge tck_i) disable iff (rst_i)
    tms_i [*5] |=> st_q == BST_TLR)
    else $error("Controller not reset after five high");
  a_ir_capture_val: assert property (@(posedge tck_i) disable iff (rst_i)
    st_q == BST_CIR |=> ir_sh_q == BST_IR_CAPTURE)
    else $error("Instruction capture pattern wrong");
  a_dead_no_scan: assert property (@(posedge tck_i) disable iff (rst_i)
    !live_tck |=> st_q == BST_TLR)
    else $error("Scan active without keepalive");
  a_update_cell: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 internal_update_cell_o == $past(dr_up_s_q[POS_UPD]))
    else $error("Update cell output mismatch");
  a_ir_no_reserved: assert property (@(posedge tck_i) disable iff (rst_i)
    ir_q != BST_RESVD)
    else $error("Reserved code became active");
  a_tdo_en_shift: assert property (@(negedge tck_i) disable iff (rst_i)
    (st_q == BST_SDR) |=> !tdo_en_n_q)
    else $error("Serial output not enabled in shift");
  a_live_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    keep_s_q[1] |=> live_q)
    else $error("Keepalive not honoured");
  a_cfg_no_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    push |-> push_rdy)
    else $error("Configure bit dropped, buffer full");
endmodule : bst_port

// File: bst_tester.sv
// Test controller model driving the scan link of the test port
`timescale 1ns/1ps
module bst_tester (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i
);
  // Link idles with its clock still and mode-select held high
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // One test clock; output sampled just before the fall
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #80 tck_o = 1'b1;
    #79 tdo = tdo_i;
    #1 tck_o = 1'b0;
  endtask : step
  // Short clock pulse so a reset sees a link edge
  task automatic tck_pulse();
    #20 tck_o = 1'b1;
    #20 tck_o = 1'b0;
  endtask : tck_pulse
  // Five clocks with mode-select high, then to idle
  task automatic reset_tap();
    logic t;
    repeat (5) step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
  endtask : reset_tap
  // Idle, select, capture, shift n bits LSB first, update, idle
  task automatic shift(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
    logic t;
    dout = '0;
    step(1'b1, 1'b0, t);
    if (ir) step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
    step(1'b0, 1'b0, t);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], t);
      dout[i] = t;
    end
    step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
    tms_o = 1'b1;
    tdi_o = ~tdi_o; // Released data line shows no stale value
  endtask : shift
endmodule : bst_tester

// File: boundary_scan_test_port_tb.sv
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
module boundary_scan_test_port_tb;
  import bst_pkg::*;
  localparam int NP  = 4;
  localparam int DRL = 2 + 3 * NP + 5 + 1;
  logic clk_i, rst_i, tck_i, tms_i, tdi_i, tdo_o, tdo_oe_n_o;
  logic configuring_i, keepalive_i, user_tdo_val_i, user_tdo_oe_n_i;
  logic [NP-1:0] pad_in_i, core_out_i, core_oe_n_i, pad_out_o, pad_oe_n_o;
  logic mode_pin_zero_i, mode_pin_two_i, core_mode_one_i;
  logic core_mode_one_oe_n_i, mode_pin_one_o, mode_pin_one_oe_n_o;
  logic core_tout_en_i, core_tout_val_i, user_test_out_one_i;
  logic user_test_out_two_i, readback_bit_i, config_dout_i;
  logic internal_update_cell_o, user_tck_o, user_tms_o, user_tdi_o;
  logic cfg_valid_o, cfg_ready_i, cfg_data_o, scan_active_o;
  logic [31:0] d;
  int   bad_count = 0;
  int   tests_run = 0;

  bst_port #(.NUM_PADS(NP), .FIFO_DEPTH(16)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .tck_i(tck_i), .tms_i(tms_i),
    .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o),
    .configuring_i(configuring_i), .keepalive_i(keepalive_i),
    .user_tdo_val_i(user_tdo_val_i), .user_tdo_oe_n_i(user_tdo_oe_n_i),
    .pad_in_i(pad_in_i), .core_out_i(core_out_i),
    .core_oe_n_i(core_oe_n_i), .pad_out_o(pad_out_o),
    .pad_oe_n_o(pad_oe_n_o), .mode_pin_zero_i(mode_pin_zero_i),
    .mode_pin_two_i(mode_pin_two_i), .core_mode_one_i(core_mode_one_i),
    .core_mode_one_oe_n_i(core_mode_one_oe_n_i),
    .mode_pin_one_o(mode_pin_one_o),
    .mode_pin_one_oe_n_o(mode_pin_one_oe_n_o),
    .core_tout_en_i(core_tout_en_i), .core_tout_val_i(core_tout_val_i),
    .user_test_out_one_i(user_test_out_one_i),
    .user_test_out_two_i(user_test_out_two_i),
    .readback_bit_i(readback_bit_i), .config_dout_i(config_dout_i),
    .internal_update_cell_o(internal_update_cell_o),
    .user_tck_o(user_tck_o), .user_tms_o(user_tms_o),
    .user_tdi_o(user_tdi_o), .cfg_valid_o(cfg_valid_o),
    .cfg_ready_i(cfg_ready_i), .cfg_data_o(cfg_data_o),
    .scan_active_o(scan_active_o)
  );
  bst_tester i_tester (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i),
                       .tdo_i(tdo_o));

  // System clock, 25 ns period
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Hang guard
  initial begin
    #1000000;
    bad_count++;
    stop_test();
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : tick
  // Outputs released while reset is held
  task automatic t_reset();
    check("tdo enable", 1, tdo_oe_n_o);
    check("pad enables", 4'hF, pad_oe_n_o);
    check("cfg valid", 0, cfg_valid_o);
    check("user tms", 1, user_tms_o);
  endtask : t_reset
  // Instruction capture pattern, scan live while configuring
  task automatic t_ir_capture();
    i_tester.shift(1'b1, 3, BST_BYPASS, d);
    check("ir capture", BST_IR_CAPTURE, d[2:0]);
    check("scan active", 1, scan_active_o);
  endtask : t_ir_capture
  // Bypass and reserved codes give a one-bit delay
  task automatic t_bypass();
    logic [2:0] codes [2] = '{BST_BYPASS, BST_RESVD};
    foreach (codes[k]) begin
      i_tester.shift(1'b1, 3, codes[k], d);
      i_tester.shift(1'b0, 9, 32'h0B5, d);
      check("bypass out", {8'hB5, 1'b0}, d[8:0]);
    end
  endtask : t_bypass
  // Capture layout of the data register under sample
  task automatic t_sample();
    logic [31:0] e;
    e = '0;
    e[0] = core_tout_en_i;
    e[1] = core_tout_val_i;
    for (int p = 0; p < NP; p++) begin
      e[2+3*p] = pad_in_i[p];
      e[3+3*p] = core_out_i[p];
      e[4+3*p] = core_oe_n_i[p];
    end
    e[2+3*NP] = mode_pin_zero_i;
    e[3+3*NP] = mode_pin_two_i;
    e[5+3*NP] = core_mode_one_i;
    e[6+3*NP] = core_mode_one_oe_n_i;
    i_tester.shift(1'b1, 3, BST_SAMPLE, d);
    i_tester.shift(1'b0, DRL, 32'h0, d);
    check("sample dr", e, d & ((32'h1 << (DRL - 1)) - 1));
    check("core pads", core_out_i, pad_out_o);
    check("core enables", core_oe_n_i, pad_oe_n_o);
    check("mode one", {core_mode_one_i, core_mode_one_oe_n_i},
          {mode_pin_one_o, mode_pin_one_oe_n_o});
  endtask : t_sample
  // Preload, then pads follow the update register in external test
  task automatic t_extest();
    logic [31:0] pat;
    logic [NP-1:0] po, pe;
    pat = 32'hA5C39;
    for (int p = 0; p < NP; p++) begin
      po[p] = pat[3+3*p];
      pe[p] = pat[4+3*p];
    end
    i_tester.shift(1'b0, DRL, pat, d);
    tick(6);
    check("update cell", 1, internal_update_cell_o);
    i_tester.shift(1'b1, 3, BST_EXTEST, d);
    tick(6);
    check("extest pads", po, pad_out_o);
    check("extest enables", pe, pad_oe_n_o);
  endtask : t_extest
  // Serial output source for user, readback and configure codes
  task automatic t_sources();
    logic [2:0] codes [4] = '{BST_USER1, BST_USER2, BST_READBACK, BST_CONFIG};
    foreach (codes[k]) begin
      tick(1);
      {user_test_out_one_i, user_test_out_two_i, readback_bit_i,
       config_dout_i} = 4'h8 >> k;
      i_tester.shift(1'b1, 3, codes[k], d);
      i_tester.shift(1'b0, 4, 32'h0, d);
      check("source out", 4'hF, d[3:0]);
    end
  endtask : t_sources
  // Configure stream fills the buffer while stalled, then drains
  task automatic t_config();
    logic [15:0] q;
    int n;
    n = 0;
    q = '0;
    tick(1);
    cfg_ready_i = 1'b0;
    tick(20);
    i_tester.shift(1'b0, 16, 32'hC3A5, d);
    tick(8);
    check("cfg pending", 1, cfg_valid_o);
    cfg_ready_i = 1'b1;
    for (int c = 0; c < 100 && n < 16; c++) begin
      if (cfg_valid_o === 1'b1) begin
        q[n] = cfg_data_o;
        n++;
      end
      tick(1);
    end
    check("cfg count", 16, n);
    if (n != 16) stop_test();
    check("cfg bits", 16'hC3A5, q);
    tick(2);
    check("cfg empty", 0, cfg_valid_o);
  endtask : t_config
  // Test inputs reach user logic while the tester idles
  task automatic t_user_pins();
    tick(6);
    check("user tms", 1, user_tms_o);
    check("user tdi", tdi_i, user_tdi_o);
    check("user tck", 0, user_tck_o);
  endtask : t_user_pins
  // Keepalive keeps scan; without it the pin is a user output
  task automatic t_keepalive();
    configuring_i = 1'b0;
    keepalive_i = 1'b1;
    tick(6);
    check("kept active", 1, scan_active_o);
    i_tester.shift(1'b1, 3, BST_BYPASS, d);
    check("kept capture", BST_IR_CAPTURE, d[2:0]);
    tick(1);
    keepalive_i = 1'b0;
    user_tdo_val_i = 1'b1;
    user_tdo_oe_n_i = 1'b0;
    tick(6);
    check("scan off", 0, scan_active_o);
    check("user pin", 2'b10, {tdo_o, tdo_oe_n_o});
    user_tdo_val_i = 1'b0;
    tick(2);
    check("user pin low", 0, tdo_o);
  endtask : t_keepalive

  // Main sequence
  initial begin
    rst_i = 1'b1;
    {configuring_i, keepalive_i, user_tdo_val_i, user_tdo_oe_n_i} = 4'h9;
    pad_in_i = 4'hA;
    core_out_i = 4'h6;
    core_oe_n_i = 4'h3;
    {mode_pin_zero_i, mode_pin_two_i, core_mode_one_i} = 3'h5;
    {core_mode_one_oe_n_i, core_tout_en_i, core_tout_val_i} = 3'h2;
    {user_test_out_one_i, user_test_out_two_i} = 2'h0;
    {readback_bit_i, config_dout_i, cfg_ready_i} = 3'h1;
    i_tester.tck_pulse();
    t_reset();
    repeat (2) @(posedge clk_i);
    #2 rst_i = 1'b0;
    i_tester.reset_tap();
    t_ir_capture();
    t_bypass();
    t_sample();
    t_extest();
    t_sources();
    t_config();
    t_user_pins();
    t_keepalive();
    stop_test();
  end
endmodule : boundary_scan_test_port_tb
